// ==== design/pmf_pkg.sv ====
// Package of the digital microphone front end: register map, fields,
// path modes, decimation and high-pass constants.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package pmf_pkg;
	// ==========================================================
	// Register map (byte addresses).
	localparam logic [7:0] PMF_OFS_CTRL   = 8'h00;
	localparam logic [7:0] PMF_OFS_ROUTE  = 8'h04;
	localparam logic [7:0] PMF_OFS_STATUS = 8'h08;
	localparam logic [7:0] PMF_OFS_LEFT   = 8'h0C;
	localparam logic [7:0] PMF_OFS_RIGHT  = 8'h10;
	// ==========================================================
	// Control register fields.
	localparam int PMF_B_DIGMIC   = 0;
	localparam int PMF_B_CLK_EN   = 1;
	localparam int PMF_B_CLK_POL  = 2;
	localparam int PMF_B_DM_L     = 3;
	localparam int PMF_B_DM_R     = 4;
	localparam int PMF_B_ADC_L    = 5;
	localparam int PMF_B_ADC_R    = 6;
	localparam int PMF_B_BIAS     = 7;
	localparam int PMF_B_AMP_L    = 8;
	localparam int PMF_B_AMP_R    = 9;
	localparam int PMF_B_HPF_EN   = 10;
	localparam int PMF_B_HPF_SEL  = 11;
	localparam int PMF_B_INIT_SEL = 13;
	localparam int PMF_CTRL_W     = 15;
	// HPF on by default; cutoff and init length codes default to 00.
	localparam logic [14:0] PMF_CTRL_RST = 15'h0400;
	// Route register: adc_to_filter, filter_to_dac, filter_to_serial_out,
	// serial_in_to_dac, prog_filter_power.
	localparam int PMF_B_A2F  = 0;
	localparam int PMF_B_F2D  = 1;
	localparam int PMF_B_F2S  = 2;
	localparam int PMF_B_S2D  = 3;
	localparam int PMF_B_PFPW = 4;
	localparam logic [4:0] PMF_ROUTE_RST = 5'h05;
	// ==========================================================
	// Path modes and init state machine.
	typedef enum logic [2:0] {
		PMF_PATH_REC1_PLAY2 = 3'h0,
		PMF_PATH_REC2_PLAY1 = 3'h1,
		PMF_PATH_BYPASS     = 3'h2,
		PMF_PATH_LOOPBACK   = 3'h3,
		PMF_PATH_UNDEFINED  = 3'h4
	} pmf_path_t;
	typedef enum logic [1:0] {
		PMF_ST_IDLE = 2'h0,
		PMF_ST_INIT = 2'h1,
		PMF_ST_RUN  = 2'h3
	} pmf_state_t;
	// One decimated stereo word per fs tick.
	typedef struct packed {
		logic        valid;
		logic [23:0] left;
		logic [23:0] right;
	} pmf_sample_t;
	// ==========================================================
	// Timing: mic clock half period in system cycles, 64 bits per frame.
	localparam logic [3:0]  PMF_HALF_DIV   = 4'h4;
	localparam logic [5:0]  PMF_BITS_LAST  = 6'h3F;
	localparam logic [10:0] PMF_INIT_00    = 11'd1059;
	localparam logic [10:0] PMF_INIT_01    = 11'd267;
	localparam logic [10:0] PMF_INIT_10    = 11'd531;
	localparam logic [10:0] PMF_INIT_11    = 11'd135;
	// Ones count to 24-bit scale: 64 ones map to full positive scale.
	localparam int          PMF_ONES_SHIFT = 18;
	localparam logic [24:0] PMF_MID        = 25'h0800000;
	localparam logic [24:0] PMF_POS_MAX    = 25'h07FFFFF;
	localparam logic [24:0] PMF_NEG_MAX    = 25'h1800000;
	// DC-block shift per cutoff code; cutoff scales with fs by design.
	localparam logic [3:0]  PMF_HPF_K0     = 4'hB;
	localparam logic [3:0]  PMF_HPF_K1     = 4'h9;
	localparam logic [3:0]  PMF_HPF_K2     = 4'h6;
	localparam logic [3:0]  PMF_HPF_K3     = 4'h5;
	localparam int          PMF_FRAC       = 12;
endpackage
`default_nettype wire

// ==== design/pmf_front_end.sv ====
// Digital microphone front end: mic clock, bit capture, decimation,
// DC-block high-pass, init cycle, path mode decode and APB registers.
// Assumes the pads resolve the right pin from its output enable and
// that the power-down pin arrives asynchronously.
//
// Register access over APB and the register addresses were decided locally.
`default_nettype none
// Function
// - Select bit turns pins to mic data/clock
// - Mic clock 64fs when enabled, else low
// - Polarity 1: left on high phase
// - Polarity 0: right on high phase
// - Channel power bits gate decimation per channel
// - ADC power bits ignored by mic path
// - Power-down low releases mic pins
// - Full density range spans full 24-bit range
// - Route 1010 is record1 play2, default
// - Route 0101 is record2 play1
// - Route x000 with filter off is bypass
// - Route 1111 is loopback
// - Cutoff code selects fs-scaled DC block
// - Enable bit switches DC block on/off
// - Power-up from idle starts init cycle
// - Outputs zero during init cycle
// - Single powered channel drives both outputs
module pmf_front_end (
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                power_down_pin_n,
	input  wire logic                left_input_pin,
	output logic                     right_input_pin_out,
	output logic                     right_input_pin_oe,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	output pmf_pkg::pmf_sample_t     sample,
	output pmf_pkg::pmf_path_t       path_mode
);
	import pmf_pkg::*;

	logic [PMF_CTRL_W-1:0] ctrl_ff;
	logic [4:0]            route_ff;
	logic [1:0]            pdn_sync_ff;
	logic [1:0]            dat_sync_ff;
	logic                  mclk_ff;
	logic [3:0]            div_ff;
	logic [5:0]            bit_ff;
	logic [6:0]            ones_l_ff;
	logic [6:0]            ones_r_ff;
	logic [35:0]           dc_l_ff;
	logic [35:0]           dc_r_ff;
	logic [10:0]           init_ff;
	pmf_state_t            state_ff;
	logic                  any_pwr_d_ff;
	logic                  run;
	logic                  phase_end;
	logic                  fs_tick;
	logic                  take_l;
	logic                  take_r;
	logic                  pwr_l;
	logic                  pwr_r;
	logic                  any_pwr;
	logic [3:0]            hpf_k;
	logic [10:0]           init_len;
	logic [23:0]           dec_l;
	logic [23:0]           dec_r;
	logic [23:0]           hp_l;
	logic [23:0]           hp_r;
	logic                  wr_en;

	// Clamp a 25-bit signed value to the 24-bit range.
	function automatic logic [23:0] sat24(input logic [24:0] v);
		logic [23:0] r;
		r = v[23:0];
		if (v[24] != v[23]) begin
			r = v[24] ? PMF_NEG_MAX[23:0] : PMF_POS_MAX[23:0];
		end
		return r;
	endfunction

	// ==========================================================
	// Ones count to two's complement.
	// full-scale mapping
	function automatic logic [23:0] ones2pcm(input logic [6:0] n);
		logic [24:0] v;
		v = {n, PMF_ONES_SHIFT'(0)} - PMF_MID;
		return sat24(v);
	endfunction

	// ==========================================================
	// APB slave: zero wait states, error on unmapped offsets.
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign pslverr = psel && penable && (paddr != PMF_OFS_CTRL) &&
		(paddr != PMF_OFS_ROUTE) && (paddr != PMF_OFS_STATUS) &&
		(paddr != PMF_OFS_LEFT) && (paddr != PMF_OFS_RIGHT);

	// Writable registers; status and data are read-only.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_ff  <= PMF_CTRL_RST;
			route_ff <= PMF_ROUTE_RST;
		end else if (wr_en && paddr == PMF_OFS_CTRL) begin
			ctrl_ff <= pwdata[PMF_CTRL_W-1:0];
		end else if (wr_en && paddr == PMF_OFS_ROUTE) begin
			route_ff <= pwdata[4:0];
		end
	end

	// Read mux; reserved bits read zero.
	always_comb begin
		prdata = 32'h0;
		if (paddr == PMF_OFS_CTRL) begin
			prdata[PMF_CTRL_W-1:0] = ctrl_ff;
		end else if (paddr == PMF_OFS_ROUTE) begin
			prdata[4:0] = route_ff;
		end else if (paddr == PMF_OFS_STATUS) begin
			prdata[2:0] = path_mode;
			prdata[4:3] = state_ff;
		end else if (paddr == PMF_OFS_LEFT) begin
			prdata[23:0] = sample.left;
		end else if (paddr == PMF_OFS_RIGHT) begin
			prdata[23:0] = sample.right;
		end
	end

	// ==========================================================
	// Path decode. Routes are only changed with the filter off.
	// mode decode
	always_comb begin
		path_mode = PMF_PATH_UNDEFINED;
		if (route_ff[3:1] == 3'h0 && !route_ff[PMF_B_PFPW]) begin
			path_mode = PMF_PATH_BYPASS;
		end else if (route_ff[3:0] == 4'h5) begin
			path_mode = PMF_PATH_REC1_PLAY2;
		end else if (route_ff[3:0] == 4'hA) begin
			path_mode = PMF_PATH_REC2_PLAY1;
		end else if (route_ff[3:0] == 4'hF) begin
			path_mode = PMF_PATH_LOOPBACK;
		end
	end

	// ==========================================================
	// Pin synchronisers; the first stages feed only the second.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pdn_sync_ff <= 2'h0;
			dat_sync_ff <= 2'h0;
		end else begin
			pdn_sync_ff <= {pdn_sync_ff[0], power_down_pin_n};
			dat_sync_ff <= {dat_sync_ff[0], left_input_pin};
		end
	end

	// ==========================================================
	// Mic clock divider, 64 periods per fs frame.
	// clock gating
	assign run       = ctrl_ff[PMF_B_CLK_EN] && ctrl_ff[PMF_B_DIGMIC] &&
		pdn_sync_ff[1];
	assign phase_end = run && (div_ff == PMF_HALF_DIV - 4'h1);
	assign fs_tick   = phase_end && !mclk_ff && (bit_ff == PMF_BITS_LAST);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_ff  <= 4'h0;
			mclk_ff <= 1'b0;
			bit_ff  <= 6'h0;
		end else if (!run) begin
			div_ff  <= 4'h0;
			mclk_ff <= 1'b0;
			bit_ff  <= 6'h0;
		end else if (phase_end) begin
			div_ff  <= 4'h0;
			mclk_ff <= !mclk_ff;
			if (!mclk_ff) begin
				bit_ff <= bit_ff + 6'h1;
			end
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	assign right_input_pin_oe  = ctrl_ff[PMF_B_DIGMIC] && pdn_sync_ff[1];
	assign right_input_pin_out = mclk_ff;

	// ==========================================================
	// Capture at the end of each phase; the two-cycle synchroniser
	// lag keeps the sample well inside the phase, not on its edge.
	// phase to channel
	assign take_l = phase_end && (mclk_ff == ctrl_ff[PMF_B_CLK_POL]);
	assign take_r = phase_end && (mclk_ff != ctrl_ff[PMF_B_CLK_POL]);
	assign pwr_l   = ctrl_ff[PMF_B_DM_L];
	assign pwr_r   = ctrl_ff[PMF_B_DM_R];
	assign any_pwr = pwr_l || pwr_r;

	// First-order decimator: count ones over one 64-bit frame.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ones_l_ff <= 7'h0;
			ones_r_ff <= 7'h0;
		end else begin
			if (!pwr_l || fs_tick) begin
				ones_l_ff <= 7'h0;
			end else if (take_l) begin
				ones_l_ff <= ones_l_ff + {6'h0, dat_sync_ff[1]};
			end
			if (!pwr_r || fs_tick) begin
				ones_r_ff <= 7'h0;
			end else if (take_r) begin
				ones_r_ff <= ones_r_ff + {6'h0, dat_sync_ff[1]};
			end
		end
	end

	// The frame's last right or left bit lands in the tick cycle.
	assign dec_l = ones2pcm(ones_l_ff + {6'h0, take_l && dat_sync_ff[1]});
	assign dec_r = ones2pcm(ones_r_ff + {6'h0, take_r && dat_sync_ff[1]});

	// ==========================================================
	// DC block: running mean at fs, so cutoff tracks fs.
	// cutoff code
	always_comb begin
		case (ctrl_ff[PMF_B_HPF_SEL +: 2])
			2'h0: hpf_k = PMF_HPF_K0;
			2'h1: hpf_k = PMF_HPF_K1;
			2'h2: hpf_k = PMF_HPF_K2;
			default: hpf_k = PMF_HPF_K3;
		endcase
	end

	assign hp_l = ctrl_ff[PMF_B_HPF_EN] ? sat24({dec_l[23], dec_l} -
		{dc_l_ff[35], dc_l_ff[35:PMF_FRAC]}) : dec_l;
	assign hp_r = ctrl_ff[PMF_B_HPF_EN] ? sat24({dec_r[23], dec_r} -
		{dc_r_ff[35], dc_r_ff[35:PMF_FRAC]}) : dec_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dc_l_ff <= 36'h0;
			dc_r_ff <= 36'h0;
		end else if (!ctrl_ff[PMF_B_HPF_EN] || state_ff == PMF_ST_IDLE) begin
			dc_l_ff <= 36'h0;
			dc_r_ff <= 36'h0;
		end else if (fs_tick) begin
			dc_l_ff <= dc_l_ff + 36'(($signed({dec_l, PMF_FRAC'(0)}) -
				$signed(dc_l_ff)) >>> hpf_k);
			dc_r_ff <= dc_r_ff + 36'(($signed({dec_r, PMF_FRAC'(0)}) -
				$signed(dc_r_ff)) >>> hpf_k);
		end
	end

	// ==========================================================
	// Init cycle, counted in fs frames; it stalls if the clock stops.
	always_comb begin
		case (ctrl_ff[PMF_B_INIT_SEL +: 2])
			2'h0: init_len = PMF_INIT_00;
			2'h1: init_len = PMF_INIT_01;
			2'h2: init_len = PMF_INIT_10;
			default: init_len = PMF_INIT_11;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff     <= PMF_ST_IDLE;
			init_ff      <= 11'h0;
			any_pwr_d_ff <= 1'b0;
		end else begin
			any_pwr_d_ff <= any_pwr;
			case (state_ff)
				PMF_ST_IDLE: begin
					if (any_pwr && !any_pwr_d_ff) begin
						state_ff <= PMF_ST_INIT;
						init_ff  <= 11'h0;
					end
				end
				PMF_ST_INIT: begin
					if (!any_pwr) begin
						state_ff <= PMF_ST_IDLE;
					end else if (fs_tick) begin
						init_ff <= init_ff + 11'h1;
						if (init_ff == init_len - 11'h1) begin
							state_ff <= PMF_ST_RUN;
						end
					end
				end
				default: begin
					if (!any_pwr) begin
						state_ff <= PMF_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Output word, registered at each frame end.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sample <= '0;
		end else begin
			sample.valid <= fs_tick;
			if (fs_tick) begin
				if (state_ff != PMF_ST_RUN) begin
					sample.left  <= 24'h0;
					sample.right <= 24'h0;
				end else begin
					sample.left  <= pwr_l ? hp_l : hp_r;
					sample.right <= pwr_r ? hp_r : hp_l;
				end
			end
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_PIN_ROLE: assert property (
		right_input_pin_oe |-> ctrl_ff[PMF_B_DIGMIC])
		else $error("Mic clock driven without select bit.");
	AST_CLK_LOW: assert property (
		!ctrl_ff[PMF_B_CLK_EN] |=> !right_input_pin_out)
		else $error("Mic clock not low while disabled.");
	AST_POL_MAP: assert property (
		take_l |-> mclk_ff == ctrl_ff[PMF_B_CLK_POL] && !take_r)
		else $error("Left capture on wrong phase.");
	AST_POL_RIGHT: assert property (
		take_r && !ctrl_ff[PMF_B_CLK_POL] |-> mclk_ff)
		else $error("Right capture on wrong phase.");
	AST_PWR_GATE: assert property (
		!pwr_l |=> ones_l_ff == 7'h0)
		else $error("Unpowered left channel accumulating.");
	AST_PDN_RELEASE: assert property (
		!pdn_sync_ff[1] |-> !right_input_pin_oe)
		else $error("Pin driven during power-down.");
	AST_BYPASS: assert property (
		route_ff[3:1] == 3'h0 && !route_ff[PMF_B_PFPW] |->
		path_mode == PMF_PATH_BYPASS)
		else $error("Bypass mode not decoded.");
	AST_LOOP: assert property (
		route_ff[3:0] == 4'hF |-> path_mode == PMF_PATH_LOOPBACK)
		else $error("Loopback mode not decoded.");
	AST_INIT_START: assert property (
		state_ff == PMF_ST_IDLE && any_pwr && !any_pwr_d_ff |=>
		state_ff == PMF_ST_INIT)
		else $error("Init cycle did not start.");
	AST_INIT_ZERO: assert property (
		state_ff == PMF_ST_INIT && fs_tick |=>
		sample.left == 24'h0 && sample.right == 24'h0)
		else $error("Nonzero output during init.");
	AST_MONO: assert property (
		sample.valid && pwr_l && !pwr_r && $stable(ctrl_ff) |->
		sample.left == sample.right)
		else $error("Mono channel not duplicated.");

	CVR_FRAME: cover property (fs_tick ##1 sample.valid);
	CVR_RUN: cover property (state_ff == PMF_ST_INIT ##1
		state_ff == PMF_ST_RUN);
	CVR_LOOP: cover property (path_mode == PMF_PATH_LOOPBACK);
endmodule
`default_nettype wire

// ==== bench/pmf_mic_model.sv ====
// Behavioural one-bit microphone pair sharing one data line.
// Assumes the bench resolves the mic clock pin through its pull-down.
`default_nettype none
module pmf_mic_model (
	input  wire logic       mic_clock,
	input  wire logic       active,
	input  wire logic       polarity,
	input  wire logic [1:0] left_mode,
	input  wire logic [1:0] right_mode,
	output logic            bitstream
);
	timeunit 1ns;
	timeprecision 1ns;
	// Mode 0 sends zeros, 1 sends ones, 2 alternates each period.
	logic       alt_ff = 1'b0;
	logic       on_left;
	logic [1:0] mode;
	// The alternate pattern gives exactly half density in any frame.
	always @(posedge mic_clock) begin
		alt_ff <= ~alt_ff;
	end
	assign on_left = (mic_clock == polarity);
	assign mode    = on_left ? left_mode : right_mode;
	// released line pulled low
	// A released pin reads as the pull-down, never as a held value.
	assign bitstream = !active ? 1'b0 : (mode == 2'h2) ? alt_ff : mode[0];
endmodule
`default_nettype wire

// ==== bench/pmf_front_end_bench.sv ====
// Self-checking bench of the microphone front end.
// Assumes the design package is compiled first; APB master is local.
`default_nettype none
module pmf_front_end_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pmf_pkg::*;
	// ==========================================================
	// Stimulus and observed signals.
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        pdn_n = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pol = 1'b0;
	logic [1:0]  lmode = 2'h1;
	logic [1:0]  rmode = 2'h0;
	logic        mic_data;
	logic        pin_out;
	logic        pin_oe;
	logic        mic_clk;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	pmf_sample_t sample;
	pmf_path_t   path_mode;
	logic [31:0] q;
	logic        e;
	int          fail_count = 0;
	int          tests_run = 0;
	// The clock pin has a pull-down whenever the device lets it go.
	assign mic_clk = pin_oe ? pin_out : 1'b0;
	always #50 clock = ~clock;
	pmf_front_end pmf_front_end_inst (
		.clock(clock), .rst(rst), .power_down_pin_n(pdn_n),
		.left_input_pin(mic_data), .right_input_pin_out(pin_out),
		.right_input_pin_oe(pin_oe), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample(sample), .path_mode(path_mode));
	pmf_mic_model pmf_mic_model_inst (
		.mic_clock(mic_clk), .active(pin_oe), .polarity(pol),
		.left_mode(lmode), .right_mode(rmode), .bitstream(mic_data));
	// ==========================================================
	// Shared tasks.
	task check_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; it idles a cycle first so no strobe is set twice.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		if (pready !== 1'b1) fail_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task ctrl(input logic p, l, r, h, input logic [1:0] s);
		logic [31:0] w;
		w = 32'h0;
		w[PMF_B_DIGMIC] = 1'b1;
		w[PMF_B_CLK_EN] = 1'b1;
		w[PMF_B_CLK_POL] = p;
		w[PMF_B_DM_L] = l;
		w[PMF_B_DM_R] = r;
		w[PMF_B_ADC_L] = 1'b1;
		w[PMF_B_ADC_R] = 1'b1;
		w[PMF_B_HPF_EN] = h;
		w[PMF_B_HPF_SEL+:2] = s;
		w[PMF_B_INIT_SEL+:2] = 2'h3;
		// Bias and amplifier bits stay clear while a mic is in use.
		apb(1'b1, PMF_OFS_CTRL, w);
		pol <= p;
	endtask
	// Returns at a settled point in the cycle where valid is high.
	task wait_frames(input int n);
		int c;
		int g;
		c = 0;
		g = 0;
		while (c < n && g < n * 600 + 100) begin
			@(negedge clock);
			g++;
			if (sample.valid === 1'b1) c++;
		end
		if (c < n) fail_count++;
	endtask
	task count_clk(input int n, output int hi, output int rise);
		logic last;
		hi = 0;
		rise = 0;
		last = mic_clk;
		repeat (n) begin
			@(negedge clock);
			if (mic_clk === 1'b1) hi++;
			if (mic_clk === 1'b1 && last === 1'b0) rise++;
			last = mic_clk;
		end
	endtask
	task check_lr(input logic [23:0] l, input logic [23:0] r);
		check_word({8'h0, sample.left}, {8'h0, l});
		check_word({8'h0, sample.right}, {8'h0, r});
	endtask
	// ==========================================================
	// Scenarios.
	task test_reset;
		apb(1'b0, PMF_OFS_CTRL, 32'h0);
		check_word(q, {17'h0, PMF_CTRL_RST});
		apb(1'b0, PMF_OFS_ROUTE, 32'h0);
		check_word(q, {27'h0, PMF_ROUTE_RST});
		check_word({29'h0, path_mode}, {29'h0, PMF_PATH_REC1_PLAY2});
		check_word({31'h0, pin_oe}, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check_word({q[30:0], e}, 32'h1);
		$display("test reset done");
	endtask
	task test_routes;
		logic [4:0] rv [6] = '{5'h05, 5'h0A, 5'h00, 5'h01, 5'h0F, 5'h10};
		pmf_path_t  pm [6] = '{PMF_PATH_REC1_PLAY2, PMF_PATH_REC2_PLAY1,
			PMF_PATH_BYPASS, PMF_PATH_BYPASS, PMF_PATH_LOOPBACK,
			PMF_PATH_UNDEFINED};
		// Filter power is set only in the last entry, with all route bits clear.
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, PMF_OFS_ROUTE, {27'h0, rv[i]});
			@(negedge clock);
			check_word({29'h0, path_mode}, {29'h0, pm[i]});
			apb(1'b0, PMF_OFS_STATUS, 32'h0);
			check_word({29'h0, q[2:0]}, {29'h0, pm[i]});
		end
		apb(1'b1, PMF_OFS_ROUTE, 32'h0);
		apb(1'b1, PMF_OFS_ROUTE, {27'h0, PMF_ROUTE_RST});
		$display("test routes done");
	endtask
	task test_clock;
		int hi;
		int rise;
		ctrl(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
		count_clk(64, hi, rise);
		check_word(hi, 32);
		check_word(rise, 8);
		apb(1'b1, PMF_OFS_CTRL, 32'h1 << PMF_B_DIGMIC);
		count_clk(64, hi, rise);
		check_word(hi, 0);
		check_word({31'h0, pin_oe}, 32'h1);
		@(posedge clock);
		pdn_n <= 1'b0;
		count_clk(8, hi, rise);
		check_word({31'h0, pin_oe}, 32'h0);
		@(posedge clock);
		pdn_n <= 1'b1;
		$display("test clock done");
	endtask
	task test_init;
		int k;
		logic done;
		done = 1'b0;
		lmode <= 2'h1;
		rmode <= 2'h0;
		// Clocks keep running for the whole mic session.
		ctrl(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
		for (k = 1; k <= 140 && !done; k++) begin
			wait_frames(1);
			if (k == 2 || k == 130) check_lr(24'h0, 24'h0);
			if (k == 2 || k >= PMF_INIT_11 - 2) begin
				apb(1'b0, PMF_OFS_STATUS, 32'h0);
				if (k == 2) check_word({30'h0, q[4:3]}, 32'h1);
				done = (q[4:3] == 2'h3);
			end
		end
		check_word(k >= PMF_INIT_11 && k <= PMF_INIT_11 + 2, 32'h1);
		wait_frames(2);
		check_lr(24'h7FFFFF, 24'h7FFFFF);
		$display("test init done");
	endtask
	task test_stereo;
		ctrl(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
		rmode <= 2'h2;
		wait_frames(2);
		check_lr(24'h7FFFFF, 24'h0);
		ctrl(1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
		lmode <= 2'h0;
		rmode <= 2'h1;
		wait_frames(2);
		check_lr(24'h800000, 24'h7FFFFF);
		apb(1'b0, PMF_OFS_LEFT, 32'h0);
		check_word(q, 32'h00800000);
		ctrl(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
		wait_frames(2);
		check_lr(24'h800000, 24'h800000);
		ctrl(1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
		wait_frames(2);
		check_lr(24'h7FFFFF, 24'h7FFFFF);
		$display("test stereo done");
	endtask
	task test_hpf;
		// The slowest cutoff barely moves; the fastest pulls DC away.
		ctrl(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
		wait_frames(8);
		check_word(sample.right > 24'h780000 && !sample.right[23], 32'h1);
		ctrl(1'b1, 1'b0, 1'b1, 1'b1, 2'h3);
		wait_frames(20);
		check_word(sample.right < 24'h500000, 32'h1);
		ctrl(1'b1, 1'b0, 1'b1, 1'b0, 2'h3);
		wait_frames(2);
		check_lr(24'h7FFFFF, 24'h7FFFFF);
		$display("test hpf done");
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog.
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		test_reset;
		test_routes;
		test_clock;
		test_init;
		test_stereo;
		test_hpf;
		final_report;
	end
	// The init cycle alone takes about 70000 cycles of the run.
	initial begin
		repeat (110000) @(posedge clock);
		fail_count++;
		$display("watchdog expired");
		final_report;
	end
endmodule
`default_nettype wire
